// *** logic/quad_rate_burst_sram_port.sv ***
// Burst memory port with separate double-rate read and write data paths
`timescale 1ns/100ps
`default_nettype none
module quad_rate_burst_sram_port (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic                          k_clk,
  input  wire logic                          k_n_clk,
  input  wire logic [quad_burst_pkg::ADDR_W-1:0] addr,
  input  wire logic                          read_port_select_n,
  input  wire logic                          write_port_select_n,
  input  wire logic [quad_burst_pkg::DATA_W-1:0] data_in,
  input  wire logic                          loop_bypass_pin,
  output logic      [quad_burst_pkg::DATA_W-1:0] data_out,
  output logic                               read_valid_flag,
  output logic                               echo_strobe,
  output logic                               echo_strobe_n,
  output logic      [quad_burst_pkg::ADDR_W-1:0] journal_addr,
  output logic                               journal_valid,
  input  wire logic                          journal_ready,
  output logic                               journal_overflow
);
  import quad_burst_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              link_rst_meta;
  logic              link_rst;
  logic              ce_k;
  logic              bypass_k;
  logic [2:0]        lat_halves;
  slot_type          slot;
  logic              rd_v [0:RD_STAGES-1];
  logic [ADDR_W-1:0] rd_a [0:RD_STAGES-1];
  logic              wr_v [0:WR_STAGES-1];
  logic [ADDR_W-1:0] wr_a [0:WR_STAGES-1];
  logic [DATA_W-1:0] bank_even [0:BANK_DEPTH-1];
  logic [DATA_W-1:0] bank_odd  [0:BANK_DEPTH-1];
  logic [DATA_W-1:0] q_rise;
  logic [DATA_W-1:0] q_fall;
  logic              vld_rise;
  logic              vld_fall;
  logic [DATA_W-1:0] next_q_rise;
  logic [DATA_W-1:0] next_q_fall;
  logic              next_vld_rise;
  logic              next_vld_fall;
  logic              wr_hit_rise;
  logic              wr_hit_fall;
  logic [ADDR_W:0]   wr_loc_rise;
  logic [ADDR_W:0]   wr_loc_fall;
  logic              req_tgl;
  logic              ack_k;
  logic [ADDR_W-1:0] hold_addr;
  logic              drop_k;
  logic              req_clk;
  logic              ack_tgl;
  logic              take;

  stream_if #(.W(ADDR_W)) push_s ();
  stream_if #(.W(ADDR_W)) pop_s ();

  // ----------------------------------------------------------------
  // Link-domain reset and level crossings
  // ----------------------------------------------------------------

  // Reset asserts at once and releases on a master clock edge
  always_ff @(posedge k_clk or posedge rst) begin
    if (rst) begin
      link_rst_meta <= 1'b1;
      link_rst      <= 1'b1;
    end else begin
      link_rst_meta <= 1'b0;
      link_rst      <= link_rst_meta;
    end
  end

  sync_stage #(.W(1)) u_ce_sync (
    .clk (k_clk),
    .rst (link_rst),
    .d   (ce),
    .q   (ce_k)
  );

  // The bypass strap is a board level, so it is synchronised like ce
  sync_stage #(.W(1)) u_bypass_sync (
    .clk (k_clk),
    .rst (link_rst),
    .d   (loop_bypass_pin),
    .q   (bypass_k)
  );

  sync_stage #(.W(1)) u_ack_sync (
    .clk (k_clk),
    .rst (link_rst),
    .d   (ack_tgl),
    .q   (ack_k)
  );

  // Read latency selection follows the strap
  always_ff @(posedge k_clk or posedge link_rst) begin
    if (link_rst) begin
      lat_halves <= LAT_HALVES_LEGACY;
    end else if (ce_k) begin
      lat_halves <= bypass_k ? LAT_HALVES_BYPASS : LAT_HALVES_LEGACY;
    end
  end

  // ----------------------------------------------------------------
  // Address capture on the true clock
  // ----------------------------------------------------------------

  // Slots alternate every edge; a select outside its slot is ignored
  always_ff @(posedge k_clk or posedge link_rst) begin
    if (link_rst) begin
      slot <= SLOT_RD;
    end else if (ce_k) begin
      case (slot)
        SLOT_RD: slot <= SLOT_WR;
        SLOT_WR: slot <= SLOT_RD;
        default: slot <= SLOT_RD;
      endcase
    end
  end

  // Age pipelines: stage s means captured s+1 edges ago
  always_ff @(posedge k_clk or posedge link_rst) begin
    if (link_rst) begin
      for (int s = 0; s < RD_STAGES; s++) begin
        rd_v[s] <= 1'b0;
        rd_a[s] <= ADDR_RESET;
      end
      for (int s = 0; s < WR_STAGES; s++) begin
        wr_v[s] <= 1'b0;
        wr_a[s] <= ADDR_RESET;
      end
    end else if (ce_k) begin
      rd_v[0] <= (slot == SLOT_RD) && !read_port_select_n;
      rd_a[0] <= addr;
      wr_v[0] <= (slot == SLOT_WR) && !write_port_select_n;
      wr_a[0] <= addr;
      for (int s = 1; s < RD_STAGES; s++) begin
        rd_v[s] <= rd_v[s-1];
        rd_a[s] <= rd_a[s-1];
      end
      for (int s = 1; s < WR_STAGES; s++) begin
        wr_v[s] <= wr_v[s-1];
        wr_a[s] <= wr_a[s-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write word decode for each edge
  // ----------------------------------------------------------------

  // True edge sees stage s at 2s+2 half cycles; writes land on even words
  always_comb begin
    logic [3:0] pos;
    pos         = 4'h0;
    wr_hit_rise = 1'b0;
    wr_loc_rise = '0;
    for (int s = 0; s < WR_STAGES; s++) begin
      pos = 4'(2 * s + 2) - {1'b0, WR_LAT_HALVES};
      if (wr_v[s] && pos < 4'(BURST_LEN)) begin
        wr_hit_rise = 1'b1;
        wr_loc_rise = {wr_a[s], pos[1]};
      end
    end
  end

  // Complementary edge sees stage s at 2s+1 half cycles; odd words
  always_comb begin
    logic [3:0] pos;
    pos         = 4'h0;
    wr_hit_fall = 1'b0;
    wr_loc_fall = '0;
    for (int s = 0; s < WR_STAGES; s++) begin
      pos = 4'(2 * s + 1) - {1'b0, WR_LAT_HALVES};
      if (wr_v[s] && pos < 4'(BURST_LEN)) begin
        wr_hit_fall = 1'b1;
        wr_loc_fall = {wr_a[s], pos[1]};
      end
    end
  end

  // Each word goes into the array the edge it is registered, so no
  // write strobe timing is asked of the controller
  always_ff @(posedge k_clk) begin
    if (ce_k && !link_rst && wr_hit_rise) begin
      bank_even[wr_loc_rise] <= data_in;
    end
  end

  always_ff @(posedge k_n_clk) begin
    if (ce_k && !link_rst && wr_hit_fall) begin
      bank_odd[wr_loc_fall] <= data_in;
    end
  end

  // ----------------------------------------------------------------
  // Read word fetch for each edge
  // ----------------------------------------------------------------

  // A word written on this very edge is taken straight from the data_in pins
  always_comb begin
    logic [3:0]      pos;
    logic [ADDR_W:0] loc;
    pos           = 4'h0;
    loc           = '0;
    next_q_rise   = DATA_RESET;
    next_vld_rise = 1'b0;
    for (int s = 0; s < RD_STAGES; s++) begin
      pos = 4'(2 * s + 2) - {1'b0, lat_halves};
      if (rd_v[s] && pos < 4'(BURST_LEN)) begin
        loc           = {rd_a[s], pos[1]};
        next_vld_rise = 1'b1;
        if (pos[0]) begin
          next_q_rise = bank_odd[loc];
        end else if (wr_hit_rise && wr_loc_rise == loc) begin
          next_q_rise = data_in;
        end else begin
          next_q_rise = bank_even[loc];
        end
      end
    end
  end

  always_comb begin
    logic [3:0]      pos;
    logic [ADDR_W:0] loc;
    pos           = 4'h0;
    loc           = '0;
    next_q_fall   = DATA_RESET;
    next_vld_fall = 1'b0;
    for (int s = 0; s < RD_STAGES; s++) begin
      pos = 4'(2 * s + 1) - {1'b0, lat_halves};
      if (rd_v[s] && pos < 4'(BURST_LEN)) begin
        loc           = {rd_a[s], pos[1]};
        next_vld_fall = 1'b1;
        if (!pos[0]) begin
          next_q_fall = bank_even[loc];
        end else if (wr_hit_fall && wr_loc_fall == loc) begin
          next_q_fall = data_in;
        end else begin
          next_q_fall = bank_odd[loc];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers on both rising edges
  // ----------------------------------------------------------------

  // Read path shares only the banks and the data_in forward with the write path, so both run at once
  always_ff @(posedge k_clk or posedge link_rst) begin
    if (link_rst) begin
      q_rise   <= DATA_RESET;
      vld_rise <= 1'b0;
    end else if (ce_k) begin
      q_rise   <= next_q_rise;
      vld_rise <= next_vld_rise;
    end
  end

  always_ff @(posedge k_n_clk or posedge link_rst) begin
    if (link_rst) begin
      q_fall   <= DATA_RESET;
      vld_fall <= 1'b0;
    end else if (ce_k) begin
      q_fall   <= next_q_fall;
      vld_fall <= next_vld_fall;
    end
  end

  // Double-rate pad mux: each half cycle shows the register of its edge
  assign data_out        = k_clk ? q_rise : q_fall;
  assign read_valid_flag = k_clk ? vld_rise : vld_fall;

  // Echo clocks follow the master clocks so data and strobe stay aligned
  assign echo_strobe   = k_clk;
  assign echo_strobe_n = k_n_clk;

  // ----------------------------------------------------------------
  // Write journal: committed burst addresses cross to the core clock
  // ----------------------------------------------------------------

  // Toggle handshake; the held address stays still until acknowledged.
  // A commit arriving while busy is dropped and reported, since the
  // memory controller cannot be stalled.
  always_ff @(posedge k_clk or posedge link_rst) begin
    if (link_rst) begin
      req_tgl   <= 1'b0;
      hold_addr <= ADDR_RESET;
      drop_k    <= 1'b0;
    end else if (ce_k && wr_v[COMMIT_STAGE]) begin
      if (req_tgl == ack_k) begin
        req_tgl   <= ~req_tgl;
        hold_addr <= wr_a[COMMIT_STAGE];
      end else begin
        drop_k <= 1'b1;
      end
    end
  end

  sync_stage #(.W(1)) u_req_sync (
    .clk (clk),
    .rst (rst),
    .d   (req_tgl),
    .q   (req_clk)
  );

  sync_stage #(.W(1)) u_drop_sync (
    .clk (clk),
    .rst (rst),
    .d   (drop_k),
    .q   (journal_overflow)
  );

  // Buffer back-pressure holds the acknowledge, so the next link-side commit waits in hold_addr and any after it are dropped
  assign take          = ce && (req_clk != ack_tgl) && push_s.ready;
  assign push_s.valid  = ce && (req_clk != ack_tgl);
  assign push_s.data   = hold_addr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_tgl <= 1'b0;
    end else if (take) begin
      ack_tgl <= ~ack_tgl;
    end
  end

  two_entry_buffer #(.W(ADDR_W)) u_journal_buf (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .fill  (push_s),
    .drain (pop_s)
  );

  assign journal_addr  = pop_s.data;
  assign journal_valid = pop_s.valid;
  assign pop_s.ready   = journal_ready;

endmodule : quad_rate_burst_sram_port
`default_nettype wire

// *** logic/quad_burst_pkg.sv ***
// Shared constants and types for the four-word double-rate burst memory port
package quad_burst_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int DATA_W     = 18;
  localparam int ADDR_W     = 4;
  localparam int BURST_LEN  = 4;
  localparam int BANK_DEPTH = (1 << ADDR_W) * 2;   // Even or odd words of every burst
  localparam int RD_STAGES  = 4;                   // Covers the longest read latency
  localparam int WR_STAGES  = 3;                   // Last stage is the commit point

  // ----------------------------------------------------------------
  // Latencies in half cycles of the master clock
  // ----------------------------------------------------------------
  localparam logic [2:0] LAT_HALVES_BYPASS = 3'h5;   // 2.5 cycles
  localparam logic [2:0] LAT_HALVES_LEGACY = 3'h2;   // 1 cycle
  localparam logic [2:0] WR_LAT_HALVES     = 3'h2;   // First write word one cycle after address
  localparam int         COMMIT_STAGE      = WR_STAGES - 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 4'h0;

  // Address slot on the shared bus
  typedef enum logic [0:0] {
    SLOT_RD = 1'b0,
    SLOT_WR = 1'b1
  } slot_type;

endpackage : quad_burst_pkg

// *** logic/stream_if.sv ***
// Valid/ready stream carrier between the port core and its buffer
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(
  parameter int W = 4
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// *** logic/sync_stage.sv ***
// Two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module sync_stage #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First flop feeds only the second one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync_stage
`default_nettype wire

// *** logic/two_entry_buffer.sv ***
// Two-entry flop buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(
  parameter int W = 4
) (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  stream_if.sink      fill,
  stream_if.source    drain
);
  logic [W-1:0] slots [0:1];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  // Honest full and empty drive the handshakes
  assign fill.ready  = (count != 2'h2);
  assign drain.valid = (count != 2'h0);
  assign drain.data  = slots[rd_ptr];
  assign push        = ce && fill.valid && fill.ready;
  assign pop         = ce && drain.valid && drain.ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      slots[wr_ptr] <= fill.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : two_entry_buffer
`default_nettype wire

// *** testbench/burst_host_model.sv ***
// Memory controller model: master clocks, address slots and double-rate write data
`timescale 1ns/100ps
`default_nettype none
module burst_host_model (
  input  wire logic                              rst,
  output logic                                   k_clk,
  output logic                                   k_n_clk,
  output logic [quad_burst_pkg::ADDR_W-1:0]      addr,
  output logic                                   read_port_select_n,
  output logic                                   write_port_select_n,
  output logic [quad_burst_pkg::DATA_W-1:0]      data_in
);
  import quad_burst_pkg::*;
  localparam int WD = BURST_LEN * DATA_W;
  localparam int JW = 2 * ADDR_W + 2 + WD;
  logic [JW-1:0] jobs[$];
  logic [JW-1:0] job;
  logic [WD-1:0] pend;

  // ---------------------------------------------------------------
  // Master clocks
  // ---------------------------------------------------------------
  // Free running, 12 ns, phase unrelated to the core clock
  initial begin
    k_clk = 1'b0;
    #3.3;
    forever #6 k_clk = ~k_clk;
  end
  assign k_n_clk = ~k_clk;

  // One slot pair per job keeps the issue rate legal
  task automatic post(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                      input logic [ADDR_W-1:0] wa, input logic [WD-1:0] wd);
    jobs.push_back({rd, ra, wr, wa, wd});
  endtask : post

  // ---------------------------------------------------------------
  // Slot driver
  // ---------------------------------------------------------------
  // Idle lines carry inverted data so stale values never look valid
  initial begin
    addr = ADDR_RESET;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    data_in = DATA_RESET;
    pend = '0;
    @(negedge rst);
    // Link reset and the enable synchroniser use four edges; the fifth is the first read slot
    repeat (4) @(posedge k_clk);
    #1;
    forever begin
      job = (jobs.size() > 0) ? jobs.pop_front() : {1'b0, ~addr, 1'b0, ~addr, ~pend};
      addr = job[JW-2 -: ADDR_W];
      read_port_select_n = ~job[JW-1];
      data_in = pend[0 +: DATA_W];
      @(posedge k_clk) #1;
      addr = job[WD +: ADDR_W];
      write_port_select_n = ~job[WD+ADDR_W];
      read_port_select_n = 1'b1;
      data_in = pend[DATA_W +: DATA_W];
      @(posedge k_n_clk) #1;
      data_in = pend[2*DATA_W +: DATA_W];
      @(posedge k_clk) #1;
      write_port_select_n = 1'b1;
      data_in = pend[3*DATA_W +: DATA_W];
      @(posedge k_n_clk) #1;
      pend = job[WD-1:0];
    end
  end
endmodule : burst_host_model
`default_nettype wire

// *** testbench/quad_rate_burst_sram_port_props.sv ***
// Checker for the burst memory port, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module quad_rate_burst_sram_port_props (
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic                              ce,
  input wire logic                              k_clk,
  input wire logic                              k_n_clk,
  input wire logic [quad_burst_pkg::ADDR_W-1:0] addr,
  input wire logic                              read_port_select_n,
  input wire logic                              write_port_select_n,
  input wire logic [quad_burst_pkg::DATA_W-1:0] data_in,
  input wire logic                              loop_bypass_pin,
  input wire logic [quad_burst_pkg::DATA_W-1:0] data_out,
  input wire logic                              read_valid_flag,
  input wire logic                              echo_strobe,
  input wire logic                              echo_strobe_n,
  input wire logic [quad_burst_pkg::ADDR_W-1:0] journal_addr,
  input wire logic                              journal_valid,
  input wire logic                              journal_ready,
  input wire logic                              journal_overflow
);
  import quad_burst_pkg::*;
  logic [1:0] k_edges;
  logic       odd;
  logic [5:1] tk;
  logic       rd_take;

  // ---------------------------------------------------------------
  // Slot tracking
  // ---------------------------------------------------------------
  // Assumes ce stays high; the fifth edge after release is the first read slot
  assign rd_take = (k_edges == 2'h3) && odd && !read_port_select_n;
  always_ff @(posedge k_clk or posedge rst) begin
    if (rst) begin
      k_edges <= 2'h0;
      odd <= 1'b1;
      tk <= '0;
    end else begin
      k_edges <= (k_edges == 2'h3) ? k_edges : k_edges + 2'h1;
      odd <= ~odd;
      tk <= {tk[4:1], rd_take};
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  valid_low_half_a : assert property (@(posedge k_clk) disable iff (rst)
    read_valid_flag == (loop_bypass_pin ? (tk[3] | tk[4]) : (tk[2] | tk[3])))
    else $error("read valid wrong in low phase");
  valid_high_half_a : assert property (@(negedge k_clk) disable iff (rst)
    read_valid_flag == (loop_bypass_pin ? (tk[4] | tk[5]) : (tk[2] | tk[3])))
    else $error("read valid wrong in high phase");
  echo_low_a : assert property (@(posedge k_clk) disable iff (rst) !echo_strobe && echo_strobe_n)
    else $error("echo pair wrong while clock low");
  echo_high_a : assert property (@(negedge k_clk) disable iff (rst) echo_strobe && !echo_strobe_n)
    else $error("echo pair wrong while clock high");
  read_quiet_a : assert property (@(posedge k_clk) disable iff (rst)
    $fell(rst) |-> !read_valid_flag && data_out == DATA_RESET)
    else $error("read port busy after reset");
  journal_quiet_a : assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !journal_valid && !journal_overflow)
    else $error("journal busy after reset");
  journal_hold_a : assert property (@(posedge clk) disable iff (rst)
    journal_valid && !(journal_ready && ce) |=> journal_valid && $stable(journal_addr))
    else $error("journal word lost while stalled");
  overflow_sticky_a : assert property (@(posedge clk) disable iff (rst)
    journal_overflow |=> journal_overflow)
    else $error("overflow flag cleared without reset");

  read_bypass_c : cover property (@(posedge k_clk) disable iff (rst) rd_take && loop_bypass_pin);
  read_legacy_c : cover property (@(posedge k_clk) disable iff (rst) rd_take && !loop_bypass_pin);
  overflow_c : cover property (@(posedge clk) disable iff (rst) $rose(journal_overflow));
endmodule : quad_rate_burst_sram_port_props

bind quad_rate_burst_sram_port quad_rate_burst_sram_port_props props_u (
  .clk(clk), .rst(rst), .ce(ce), .k_clk(k_clk), .k_n_clk(k_n_clk), .addr(addr),
  .read_port_select_n(read_port_select_n), .write_port_select_n(write_port_select_n),
  .data_in(data_in), .loop_bypass_pin(loop_bypass_pin), .data_out(data_out),
  .read_valid_flag(read_valid_flag), .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n),
  .journal_addr(journal_addr), .journal_valid(journal_valid), .journal_ready(journal_ready),
  .journal_overflow(journal_overflow)
);
`default_nettype wire

// *** testbench/quad_rate_burst_sram_port_tb.sv ***
// Self-checking bench for the burst memory port
`timescale 1ns/100ps
`default_nettype none
module quad_rate_burst_sram_port_tb;
  import quad_burst_pkg::*;
  localparam int WD = BURST_LEN * DATA_W;
  logic              clk, rst, ce, loop_bypass_pin, journal_ready;
  logic              k_clk, k_n_clk, read_port_select_n, write_port_select_n;
  logic              read_valid_flag, echo_strobe, echo_strobe_n, journal_valid, journal_overflow;
  logic [ADDR_W-1:0] addr, journal_addr;
  logic [DATA_W-1:0] data_in, data_out;
  logic [DATA_W-1:0] got_r[$];
  logic [DATA_W-1:0] exp_r[$];
  logic [ADDR_W-1:0] got_j[$];
  int                fails = 0;
  int                n_tests = 0;

  quad_rate_burst_sram_port dut_u (
    .clk(clk), .rst(rst), .ce(ce), .k_clk(k_clk), .k_n_clk(k_n_clk), .addr(addr),
    .read_port_select_n(read_port_select_n), .write_port_select_n(write_port_select_n),
    .data_in(data_in), .loop_bypass_pin(loop_bypass_pin), .data_out(data_out),
    .read_valid_flag(read_valid_flag), .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n),
    .journal_addr(journal_addr), .journal_valid(journal_valid), .journal_ready(journal_ready),
    .journal_overflow(journal_overflow)
  );
  burst_host_model host_u (
    .rst(rst), .k_clk(k_clk), .k_n_clk(k_n_clk), .addr(addr), .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .data_in(data_in)
  );

  // ---------------------------------------------------------------
  // Clock and monitors
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Read words sampled mid-phase, clear of the launching edge
  always @(posedge k_clk or posedge k_n_clk) begin
    #3;
    if (read_valid_flag === 1'b1) got_r.push_back(data_out);
  end
  // Falling edge sees what the next rising edge pops
  always @(negedge clk) begin
    if (journal_valid === 1'b1 && journal_ready === 1'b1) got_j.push_back(journal_addr);
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit
  // Bounded wait on clk; running out ends the run as a failure
  task automatic wait_for(input int rd_n, input int jr_n);
    for (int i = 0; i < 400 && (got_r.size() < rd_n || got_j.size() < jr_n); i++) @(posedge clk);
    #1;
    if (got_r.size() < rd_n || got_j.size() < jr_n) begin
      fails++;
      close_out();
    end
  endtask : wait_for
  function automatic logic [WD-1:0] burst(input logic [7:0] s, input logic [ADDR_W-1:0] a);
    return {s, a, 4'h9, 2'h3, s, a, 4'h9, 2'h2, s, a, 4'h9, 2'h1, s, a, 4'h9, 2'h0};
  endfunction : burst
  task automatic idle(input int n);
    repeat (n) host_u.post(1'b0, 4'h0, 1'b0, 4'h0, '0);
  endtask : idle

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset();
    check_bit(read_valid_flag, 1'b0);
    check_word(data_out, DATA_RESET);
    check_bit(journal_valid, 1'b0);
    check_bit(journal_overflow, 1'b0);
  endtask : sc_reset
  // Writes spaced so each journal handshake settles; reads hit in-flight writes
  task automatic sc_traffic(input logic bp, input logic [7:0] s);
    logic [WD-1:0] b[3];
    b[0] = burst(s, 4'h1);
    b[1] = burst(s, 4'h2);
    b[2] = burst(~s, 4'h1);
    loop_bypass_pin = bp;
    repeat (12) @(posedge clk);
    #1;
    got_r.delete();
    exp_r.delete();
    got_j.delete();
    host_u.post(1'b0, 4'h0, 1'b1, 4'h1, b[0]);
    idle(3);
    host_u.post(1'b1, 4'h1, 1'b1, 4'h2, b[1]);
    host_u.post(1'b1, 4'h2, 1'b0, 4'h0, '0);
    idle(2);
    host_u.post(1'b0, 4'h0, 1'b1, 4'h1, b[2]);
    host_u.post(1'b1, 4'h1, 1'b0, 4'h0, '0);
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < BURST_LEN; i++) exp_r.push_back(b[k][i*DATA_W +: DATA_W]);
    end
    wait_for(12, 3);
    repeat (20) @(posedge clk);
    check_word(DATA_W'(got_r.size()), DATA_W'(12));
    for (int i = 0; i < 12; i++) check_word(got_r[i], exp_r[i]);
    check_word(DATA_W'(got_j[0]), DATA_W'(1));
    check_word(DATA_W'(got_j[1]), DATA_W'(2));
    check_word(DATA_W'(got_j[2]), DATA_W'(1));
  endtask : sc_traffic
  // Stalled consumer: buffer fills, a later commit is dropped, then drain to empty
  task automatic sc_fill();
    journal_ready = 1'b0;
    got_j.delete();
    for (int i = 0; i < 4; i++) begin
      host_u.post(1'b0, 4'h0, 1'b1, 4'(i + 3), burst(8'h11, 4'(i + 3)));
      idle(3);
    end
    for (int i = 0; i < 400 && host_u.jobs.size() > 0; i++) @(posedge clk);
    if (host_u.jobs.size() > 0) begin
      fails++;
      close_out();
    end
    repeat (30) @(posedge clk);
    #1;
    check_bit(journal_valid, 1'b1);
    check_bit(journal_overflow, 1'b1);
    journal_ready = 1'b1;
    wait_for(0, 2);
    for (int i = 0; i < 50 && journal_valid === 1'b1; i++) @(posedge clk);
    #1;
    check_word(DATA_W'(got_j[0]), DATA_W'(3));
    check_word(DATA_W'(got_j[1]), DATA_W'(4));
    check_word(DATA_W'(got_j[2]), DATA_W'(5));
    check_word(DATA_W'(got_j.size()), DATA_W'(3));
    check_bit(journal_valid, 1'b0);
  endtask : sc_fill

  // Reset spans at least three link edges
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    loop_bypass_pin = 1'b1;
    journal_ready = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    sc_reset();
    sc_traffic(1'b1, 8'h5A);
    sc_traffic(1'b0, 8'hC3);
    sc_fill();
    close_out();
  end
endmodule : quad_rate_burst_sram_port_tb
`default_nettype wire
